/* File: shared/rxbuf_pkg.sv */
// Summary of operation
// - Each read port drives four byte enables; bit 3 is byte 31:24, bit 0 byte 7:0.
// - Port-ID flag is one when the presented word carries a port identifier.
// - Start-of-packet flag is high only with the word that begins a packet.
// - End-of-packet flag is high only with the word that ends a packet.
// - Error flag is high together with the specific word marked as errored.
// - Select bit zero, the reset default: empty flag means no words held at all.
// - Select bit one: empty flag means fill level at or below quarter capacity minus one.
// - Empty-type select is a software bit per buffer, bit index equals buffer number.
// - The second receive interface has an identical set of buffer read ports.
package rxbuf_pkg;

  localparam int NUM_IFS = 2;
  localparam int BUFS_PER_IF = 3;
  localparam int NUM_PORTS = NUM_IFS * BUFS_PER_IF;
  localparam int FIRST_BUF = 1;
  localparam int SEL_BITS = 4;
  localparam logic [31:0] EMPTY_SEL_REG_ADDR = 32'h0003_0920;
  localparam int DATA_W = 32;
  localparam int BE_W = 4;
  localparam int ADDR_W = 3;
  localparam int DEPTH = 8;
  localparam int PTR_W = 4;
  localparam logic [PTR_W-1:0] PTR_ONE = 4'h1;
  localparam logic [PTR_W-1:0] PTR_FULL = 4'h8;
  localparam logic [PTR_W-1:0] PTR_RESET = 4'h0;
  localparam logic [PTR_W-1:0] LOW_WATER = PTR_W'(DEPTH / 4 - 1);
  localparam logic EMPTY_RESET = 1'b1;
  localparam logic SEL_RESET = 1'b0;

  // One stored word with its lane enables and per-word flags.
  typedef struct packed {
    logic word_bad;
    logic pkt_last;
    logic pkt_first;
    logic portid_flag;
    logic [BE_W-1:0] byte_valid;
    logic [DATA_W-1:0] word;
  } entry_t;

  localparam entry_t ENTRY_RESET = '0;

  // Write-side state, on the core clock.
  typedef struct packed {
    logic [PTR_W-1:0] wptr;
    logic [PTR_W-1:0] wgray;
  } wr_state_t;

  // Read-side state, on the reader's clock.
  typedef struct packed {
    entry_t shown;
    logic [PTR_W-1:0] rptr;
    logic [PTR_W-1:0] rgray;
    logic empty;
    logic stop;
  } rd_state_t;

  // Binary to gray code.
  function automatic logic [PTR_W-1:0] bin2gray(input logic [PTR_W-1:0] b);
    return b ^ (b >> 1);
  endfunction : bin2gray

  // Gray code back to binary.
  function automatic logic [PTR_W-1:0] gray2bin(input logic [PTR_W-1:0] g);
    logic [PTR_W-1:0] b;
    b = '0;
    for (int i = PTR_W - 1; i >= 0; i--)
    begin
      b[i] = g[i] ^ ((i == PTR_W - 1) ? 1'b0 : b[i+1]);
    end
    return b;
  endfunction : gray2bin

endpackage : rxbuf_pkg

/* File: shared/rxbuf_ram_if.sv */
`timescale 1ns/1ps
// Storage port of one buffer: write on the core clock, read by index.
interface rxbuf_ram_if
  import rxbuf_pkg::*;
  ();
  logic we;
  logic [ADDR_W-1:0] waddr;
  entry_t wentry;
  logic [ADDR_W-1:0] raddr;
  entry_t rentry;

  modport mem (input we, input waddr, input wentry, input raddr, output rentry);
  modport user (output we, output waddr, output wentry, output raddr, input rentry);
endinterface : rxbuf_ram_if

/* File: design/rxbuf_sync.sv */
`timescale 1ns/1ps
// Two-flop synchroniser; the first stage feeds only the second.
module rxbuf_sync
  import rxbuf_pkg::*;
  #(
  parameter int W = 1
  )
  (
  input wire logic clk_i,
  input wire logic [W-1:0] async_i,
  output logic [W-1:0] sync_o
  );

  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stable;
  } sync_state_t;

  sync_state_t q, d;

  // Shift the input through both stages.
  always_comb
  begin
    d.meta = async_i;
    d.stable = q.meta;
  end

  // Data-only stages, so no reset is needed.
  always_ff @(posedge clk_i)
  begin
    q <= d;
  end

  assign sync_o = q.stable;

endmodule : rxbuf_sync

/* File: design/rxbuf_entry_ram.sv */
`timescale 1ns/1ps
// Flip-flop storage for one buffer, written on the core clock, read by index.
module rxbuf_entry_ram
  import rxbuf_pkg::*;
  (
  input wire logic clk_i,
  rxbuf_ram_if.mem ram
  );

  typedef struct packed {
    entry_t [DEPTH-1:0] mem;
  } ram_state_t;

  ram_state_t q, d;

  // Store the incoming word at the write index.
  always_comb
  begin
    d = q;
    if (ram.we)
    begin
      d.mem[ram.waddr] = ram.wentry;
    end
  end

  // Data storage carries no reset; pointers guard every read.
  always_ff @(posedge clk_i)
  begin
    q <= d;
  end

  // Reader sees the entry it indexes; gray pointers keep it stable then.
  assign ram.rentry = q.mem[ram.raddr];

endmodule : rxbuf_entry_ram

/* File: design/rxbuf_read_top.sv */
`timescale 1ns/1ps
// Receive packet buffers 1 to 3 of both receive interfaces, each with its own read clock.
// Port index p serves interface p / 3, buffer number 1 + p % 3.
module rxbuf_read_top
  import rxbuf_pkg::*;
  (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic [NUM_PORTS-1:0] wr_valid_i,
  output logic [NUM_PORTS-1:0] wr_ready_o,
  input wire logic [NUM_PORTS-1:0][DATA_W-1:0] wr_word_i,
  input wire logic [NUM_PORTS-1:0][BE_W-1:0] wr_byte_valid_i,
  input wire logic [NUM_PORTS-1:0] wr_portid_i,
  input wire logic [NUM_PORTS-1:0] wr_first_i,
  input wire logic [NUM_PORTS-1:0] wr_last_i,
  input wire logic [NUM_PORTS-1:0] wr_bad_i,
  input wire logic [NUM_IFS-1:0][SEL_BITS-1:0] empty_threshold_select_i,
  input wire logic [NUM_PORTS-1:0] rx_buf_read_clock_i,
  input wire logic [NUM_PORTS-1:0][ADDR_W-1:0] rx_buf_read_addr_i,
  input wire logic [NUM_PORTS-1:0] rx_buf_read_strobe_i,
  input wire logic [NUM_PORTS-1:0] halt_at_packet_end_i,
  output logic [NUM_PORTS-1:0][DATA_W-1:0] rx_buf_read_word_o,
  output logic [NUM_PORTS-1:0][BE_W-1:0] rx_buf_byte_valid_o,
  output logic [NUM_PORTS-1:0] rx_buf_portid_flag_o,
  output logic [NUM_PORTS-1:0] rx_buf_pkt_first_o,
  output logic [NUM_PORTS-1:0] rx_buf_pkt_last_o,
  output logic [NUM_PORTS-1:0] rx_buf_word_bad_o,
  output logic [NUM_PORTS-1:0] rx_buf_empty_flag_o
  );

  // One identical slice per buffer; each interface has its own three slices.
  for (genvar p = 0; p < NUM_PORTS; p++)
  begin : g_port
    localparam int IF_IDX = p / BUFS_PER_IF;
    localparam int BUF_NUM = FIRST_BUF + (p % BUFS_PER_IF);

    rxbuf_ram_if ram ();

    wr_state_t wr_q;
    wr_state_t wr_d;
    rd_state_t rd_q;
    rd_state_t rd_d;
    logic rd_clk;
    logic rd_rst;
    logic sel_rd;
    logic [PTR_W-1:0] rgray_core;
    logic [PTR_W-1:0] wgray_rd;
    logic [PTR_W-1:0] rbin_core;
    logic [PTR_W-1:0] wbin_rd;
    logic [PTR_W-1:0] wr_fill;
    logic full;
    logic push;
    logic [PTR_W-1:0] rd_fill;
    logic [PTR_W-1:0] next_fill;
    logic [ADDR_W-1:0] offs;
    logic refuse;
    logic take;
    logic sel_bit;

    assign rd_clk = rx_buf_read_clock_i[p];

    // The select bit for this buffer sits at the index of its buffer number.
    assign sel_bit = empty_threshold_select_i[IF_IDX][BUF_NUM];

    // Core reset, brought into the reader's clock as a level.
    rxbuf_sync #(
      .W(1)
    ) u_rst_sync (
      .clk_i(rd_clk),
      .async_i(rst_i),
      .sync_o(rd_rst)
    );

    // Empty-type select, a quasi-static software level, into the reader's clock.
    rxbuf_sync #(
      .W(1)
    ) u_sel_sync (
      .clk_i(rd_clk),
      .async_i(sel_bit),
      .sync_o(sel_rd)
    );

    // Write pointer in gray code towards the reader.
    rxbuf_sync #(
      .W(PTR_W)
    ) u_wptr_sync (
      .clk_i(rd_clk),
      .async_i(wr_q.wgray),
      .sync_o(wgray_rd)
    );

    // Read pointer in gray code back to the core.
    rxbuf_sync #(
      .W(PTR_W)
    ) u_rptr_sync (
      .clk_i(core_clk_i),
      .async_i(rd_q.rgray),
      .sync_o(rgray_core)
    );

    // Word storage shared by both domains.
    rxbuf_entry_ram u_ram (
      .clk_i(core_clk_i),
      .ram(ram.mem)
    );

    // Core side: fill level against the returned read pointer.
    assign rbin_core = gray2bin(rgray_core);
    assign wr_fill = wr_q.wptr - rbin_core;
    assign full = (wr_fill == PTR_FULL);
    assign push = wr_valid_i[p] & ~full;
    assign wr_ready_o[p] = ~full;

    // Write port of the storage; the flags are stored with their own word.
    assign ram.we = push;
    assign ram.waddr = wr_q.wptr[ADDR_W-1:0];
    assign ram.wentry.word = wr_word_i[p];
    assign ram.wentry.byte_valid = wr_byte_valid_i[p];
    assign ram.wentry.portid_flag = wr_portid_i[p];
    assign ram.wentry.pkt_first = wr_first_i[p];
    assign ram.wentry.pkt_last = wr_last_i[p];
    assign ram.wentry.word_bad = wr_bad_i[p];

    // Advance the write pointer on each accepted word.
    always_comb
    begin
      wr_d = wr_q;
      if (push)
      begin
        wr_d.wptr = wr_q.wptr + PTR_ONE;
      end
      wr_d.wgray = bin2gray(wr_d.wptr);
      if (rst_i)
      begin
        wr_d.wptr = PTR_RESET;
        wr_d.wgray = PTR_RESET;
      end
    end

    // Core-domain state.
    always_ff @(posedge core_clk_i)
    begin
      wr_q <= wr_d;
    end

    // Reader side: the address is an absolute entry index, checked against the fill relative to the read pointer.
    assign wbin_rd = gray2bin(wgray_rd);
    assign rd_fill = wbin_rd - rd_q.rptr;
    assign offs = rx_buf_read_addr_i[p] - rd_q.rptr[ADDR_W-1:0];
    assign ram.raddr = rx_buf_read_addr_i[p];

    // After a packet end under halt, strobes are ignored until the strobe drops.
    assign refuse = rd_q.stop & rx_buf_read_strobe_i[p];

    // A read is taken only when it names a word that is held.
    assign take = rx_buf_read_strobe_i[p] & ~refuse & ({1'b0, offs} < rd_fill);

    // Present the addressed word and release it and all earlier ones.
    always_comb
    begin
      rd_d = rd_q;
      if (take)
      begin
        rd_d.shown = ram.rentry;
        rd_d.rptr = rd_q.rptr + {1'b0, offs} + PTR_ONE;
        if (halt_at_packet_end_i[p] && ram.rentry.pkt_last)
        begin
          rd_d.stop = 1'b1;
        end
      end
      if (!rx_buf_read_strobe_i[p])
      begin
        rd_d.stop = 1'b0;
      end
      rd_d.rgray = bin2gray(rd_d.rptr);
      next_fill = wbin_rd - rd_d.rptr;
      if (sel_rd)
      begin
        rd_d.empty = (next_fill <= LOW_WATER);
      end
      else
      begin
        rd_d.empty = (next_fill == PTR_RESET);
      end
      if (rd_rst)
      begin
        rd_d.shown = ENTRY_RESET;
        rd_d.rptr = PTR_RESET;
        rd_d.rgray = PTR_RESET;
        rd_d.empty = EMPTY_RESET;
        rd_d.stop = 1'b0;
      end
    end

    // Reader-domain state.
    always_ff @(posedge rd_clk)
    begin
      rd_q <= rd_d;
    end

    // Word, lanes and packet flags straight from the presented entry; the empty flag comes from the read state.
    assign rx_buf_read_word_o[p] = rd_q.shown.word;
    assign rx_buf_byte_valid_o[p] = rd_q.shown.byte_valid;
    assign rx_buf_portid_flag_o[p] = rd_q.shown.portid_flag;
    assign rx_buf_pkt_first_o[p] = rd_q.shown.pkt_first;
    assign rx_buf_pkt_last_o[p] = rd_q.shown.pkt_last;
    assign rx_buf_word_bad_o[p] = rd_q.shown.word_bad;
    assign rx_buf_empty_flag_o[p] = rd_q.empty;
  end

endmodule : rxbuf_read_top

/* File: verification/rxbuf_read_sva.sv */
`timescale 1ns/1ps
// Read-side checks, mostly on port 0 of interface A.
module rxbuf_read_sva
  import rxbuf_pkg::*;
  (
  input wire logic rst_i,
  input wire logic [NUM_PORTS-1:0] rx_buf_read_clock_i,
  input wire logic [NUM_PORTS-1:0] rx_buf_read_strobe_i,
  input wire logic [NUM_PORTS-1:0] halt_at_packet_end_i,
  input wire logic [NUM_PORTS-1:0][DATA_W-1:0] rx_buf_read_word_o,
  input wire logic [NUM_PORTS-1:0][BE_W-1:0] rx_buf_byte_valid_o,
  input wire logic [NUM_PORTS-1:0] rx_buf_pkt_first_o,
  input wire logic [NUM_PORTS-1:0] rx_buf_pkt_last_o,
  input wire logic [NUM_PORTS-1:0] rx_buf_empty_flag_o
  );
  logic [2:0] rst_q;
  // Short names for the port 0 signals.
  wire logic rd = rx_buf_read_strobe_i[0];
  wire logic [DATA_W-1:0] wd = rx_buf_read_word_o[0];
  wire logic [BE_W-1:0] be = rx_buf_byte_valid_o[0];
  wire logic sop = rx_buf_pkt_first_o[0];
  wire logic eop = rx_buf_pkt_last_o[0];
  // Checks stay off until reset has crossed the read-side synchroniser.
  always_ff @(posedge rx_buf_read_clock_i[0])
  begin
    rst_q <= {rst_q[1:0], rst_i};
  end
  default clocking @(posedge rx_buf_read_clock_i[0]); endclocking
  default disable iff (rst_i || rst_q != 3'h0);
  property p_word_hold; !rd |=> $stable(wd); endproperty
  property p_be_hold; !rd |=> $stable(be); endproperty
  property p_first_hold; !rd |=> $stable(sop); endproperty
  property p_last_hold; !rd |=> $stable(eop); endproperty
  property p_empty_rise; $rose(rx_buf_empty_flag_o[0]) |-> $past(rd); endproperty
  sequence s_halted; $rose(eop) && $past(halt_at_packet_end_i[0]) && rd; endsequence
  property p_halt_word; s_halted |=> $stable(wd); endproperty
  property p_halt_flags; s_halted |=> $stable(be) && $stable(sop); endproperty
  property p_b_hold;
    @(posedge rx_buf_read_clock_i[3])
      !rx_buf_read_strobe_i[3] |=> $stable(rx_buf_read_word_o[3]);
  endproperty
  a_word_hold: assert property (p_word_hold) else $error("word moved without read");
  a_be_hold: assert property (p_be_hold) else $error("lanes moved without read");
  a_first_hold: assert property (p_first_hold) else $error("first moved");
  a_last_hold: assert property (p_last_hold) else $error("last moved");
  a_empty_rise: assert property (p_empty_rise) else $error("empty rose unread");
  a_halt_word: assert property (p_halt_word) else $error("halted read taken");
  a_halt_flags: assert property (p_halt_flags) else $error("halted flags moved");
  a_b_hold: assert property (p_b_hold) else $error("port 3 word moved");
  c_read: cover property (rd ##1 $changed(wd));
  c_empty: cover property ($rose(rx_buf_empty_flag_o[0]));
  c_halt: cover property (s_halted);
endmodule : rxbuf_read_sva

bind rxbuf_read_top rxbuf_read_sva chk_u (.rst_i, .rx_buf_read_clock_i, .rx_buf_read_strobe_i,
  .halt_at_packet_end_i, .rx_buf_read_word_o, .rx_buf_byte_valid_o, .rx_buf_pkt_first_o,
  .rx_buf_pkt_last_o, .rx_buf_empty_flag_o);

/* File: verification/rxbuf_reader_model.sv */
`timescale 1ns/1ps
// Fabric reader: makes the read clock and issues read requests.
module rxbuf_reader_model
  import rxbuf_pkg::*;
  (
  output logic rd_clk_o,
  output logic [NUM_PORTS-1:0][ADDR_W-1:0] addr_o,
  output logic [NUM_PORTS-1:0] strobe_o,
  output logic [NUM_PORTS-1:0] halt_o
  );
  // Read clock with its own phase against the core clock.
  initial
  begin
    rd_clk_o = 1'b0;
    addr_o = '0;
    strobe_o = '0;
    halt_o = '0;
    #13.7;
    forever #40 rd_clk_o = ~rd_clk_o;
  end
  // Holds the strobe over n read edges with rising addresses, then lets go.
  task automatic read_run(input int p, input logic [ADDR_W-1:0] a, input int n, input logic h);
    @(posedge rd_clk_o);
    #1;
    halt_o[p] = h;
    strobe_o[p] = 1'b1;
    for (int i = 0; i < n; i++)
    begin
      addr_o[p] = a + ADDR_W'(i);
      @(posedge rd_clk_o);
      #1;
    end
    strobe_o[p] = 1'b0;
    addr_o[p] = ~addr_o[p]; // A released address never keeps its last value.
  endtask : read_run
endmodule : rxbuf_reader_model

/* File: verification/rxbuf_read_top_bench.sv */
`timescale 1ns/1ps
module rxbuf_read_top_bench
  import rxbuf_pkg::*;
  ;
  logic core_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic rd_clk;
  logic [NUM_PORTS-1:0] wr_valid_i, wr_ready_o, wr_portid_i, wr_first_i, wr_last_i, wr_bad_i;
  logic [NUM_PORTS-1:0][DATA_W-1:0] wr_word_i, rx_buf_read_word_o;
  logic [NUM_PORTS-1:0][BE_W-1:0] wr_byte_valid_i, rx_buf_byte_valid_o;
  logic [NUM_IFS-1:0][SEL_BITS-1:0] empty_threshold_select_i = {4'he, 4'h0};
  logic [NUM_PORTS-1:0][ADDR_W-1:0] rx_buf_read_addr_i;
  logic [NUM_PORTS-1:0] rx_buf_read_strobe_i, halt_at_packet_end_i, rx_buf_portid_flag_o;
  logic [NUM_PORTS-1:0] rx_buf_pkt_first_o, rx_buf_pkt_last_o, rx_buf_word_bad_o;
  logic [NUM_PORTS-1:0] rx_buf_empty_flag_o;
  wire logic [NUM_PORTS-1:0] rx_buf_read_clock_i = {NUM_PORTS{rd_clk}};
  int errors = 0;
  int checks_done = 0;
  // Core clock.
  always #2 core_clk_i = ~core_clk_i;
  rxbuf_read_top dut_u (.core_clk_i, .rst_i, .wr_valid_i, .wr_ready_o, .wr_word_i,
    .wr_byte_valid_i, .wr_portid_i, .wr_first_i, .wr_last_i, .wr_bad_i,
    .empty_threshold_select_i, .rx_buf_read_clock_i, .rx_buf_read_addr_i, .rx_buf_read_strobe_i,
    .halt_at_packet_end_i, .rx_buf_read_word_o, .rx_buf_byte_valid_o, .rx_buf_portid_flag_o,
    .rx_buf_pkt_first_o, .rx_buf_pkt_last_o, .rx_buf_word_bad_o, .rx_buf_empty_flag_o);
  rxbuf_reader_model rd (.rd_clk_o(rd_clk), .addr_o(rx_buf_read_addr_i),
    .strobe_o(rx_buf_read_strobe_i), .halt_o(halt_at_packet_end_i));
  // Test word: flags in bits 7:4, lane enables in bits 3:0.
  function automatic logic [DATA_W-1:0] wv(input int p, input int i);
    return {p[7:0], 16'ha5c3, 4'h1 << i, 4'h8 >> i};
  endfunction : wv
  // Expected presentation of a test word: flags and lanes from its low byte, then the word.
  function automatic logic [39:0] ex(input logic [DATA_W-1:0] w);
    return {w[7:0], w};
  endfunction : ex
  // Presented word with its lanes and flags.
  function automatic logic [39:0] seen(input int p);
    return {rx_buf_word_bad_o[p], rx_buf_pkt_last_o[p], rx_buf_pkt_first_o[p],
      rx_buf_portid_flag_o[p], rx_buf_byte_valid_o[p], rx_buf_read_word_o[p]};
  endfunction : seen
  // Compares and counts.
  task automatic check(input string what, input logic [39:0] s, input logic [39:0] e);
    checks_done++;
    if (s !== e)
    begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", what, e, s);
    end
  endtask : check
  // Offers one word and holds it until the buffer takes it, giving up after 20 core clock edges of waiting.
  task automatic push(input int p, input logic [DATA_W-1:0] w);
    int n;
    n = 0;
    @(posedge core_clk_i);
    #1;
    wr_valid_i[p] = 1'b1;
    wr_word_i[p] = w;
    {wr_bad_i[p], wr_last_i[p], wr_first_i[p], wr_portid_i[p]} = w[7:4];
    wr_byte_valid_i[p] = w[3:0];
    while (wr_ready_o[p] !== 1'b1 && n++ < 20) @(posedge core_clk_i);
    @(posedge core_clk_i);
    #1;
    wr_valid_i[p] = 1'b0;
  endtask : push
  task automatic report_and_stop();
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : report_and_stop
  // Watchdog.
  initial
  begin
    #100us;
    errors++;
    report_and_stop();
  end
  // Main sequence.
  initial
  begin
    {wr_valid_i, wr_portid_i, wr_first_i, wr_last_i, wr_bad_i, wr_word_i, wr_byte_valid_i} = '0;
    repeat (16) @(posedge rd_clk);
    @(posedge core_clk_i);
    #1;
    rst_i = 1'b0;
    repeat (4) @(posedge rd_clk);
    check("reset", 40'({wr_ready_o, rx_buf_empty_flag_o}), 40'(12'hfff));
    for (int p = 0; p < NUM_PORTS; p++)
    begin
      for (int i = 0; i < 4; i++)
        push(p, wv(p, i));
      repeat (4) @(posedge rd_clk);
      check("empty4", 40'(rx_buf_empty_flag_o[p]), 40'h0);
      for (int i = 0; i < 4; i++)
      begin
        rd.read_run(p, 3'(i), 1, 1'b0);
        check("word", seen(p), ex(wv(p, i)));
        check("empty", 40'(rx_buf_empty_flag_o[p]),
          40'((p >= 3) ? (3 - i <= LOW_WATER) : (i == 3)));
      end
      rd.read_run(p, 3'h4, 1, 1'b0);
      check("refused", seen(p), ex(wv(p, 3)));
    end
    push(0, 32'h00a0_0001);
    push(0, 32'h00b0_0041);
    push(0, 32'h00c0_0011);
    repeat (4) @(posedge rd_clk);
    rd.read_run(0, 3'h4, 3, 1'b1);
    check("halted", seen(0), {8'h41, 32'h00b0_0041});
    rd.read_run(0, 3'h6, 1, 1'b0);
    check("resumed", seen(0), {8'h11, 32'h00c0_0011});
    for (int i = 0; i < DEPTH; i++)
      push(5, wv(5, i % 4));
    check("full", 40'(wr_ready_o[5]), 40'h0);
    report_and_stop();
  end
endmodule : rxbuf_read_top_bench
